// ===== tb/tb.sv
/* bench for the direction control: table of mode bytes with line levels and
   expected enables, then unmapped and mid-run reset cases. assumes uart model. */
`timescale 1ns/1ps
module tb;
  import xcvr_dir_pkg::*;
  logic        mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, send = 1, slot = 0;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic        dtr_n, slot_ready_n, line_drv_en, line_rcv_en;
  int          mismatches = 0, samples_checked = 0;
  // mode byte, send, slot, expected driver, expected receiver
  logic [11:0] rows [8] = '{12'h003, 12'hfcf, 12'h01b, 12'h015,
                            12'h02a, 12'h021, 12'hff6, 12'h039};
  always #25 mclk = ~mclk;
  uart_side_model i_uart (.send(send), .tx_slot(slot), .dtr_n(dtr_n),
    .slot_ready_n(slot_ready_n));
  rs485_transceiver_direction_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .uart_dtr_n(dtr_n), .uart_tx_slot_ready_n(slot_ready_n), .line_drv_en(line_drv_en),
    .line_rcv_en(line_rcv_en));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge mclk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge mclk);
    reg_rd = 0;
    chk(reg_rdata, exp);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge mclk);
    rst_n = 1;
    chk({6'h00, line_drv_en, line_rcv_en}, 8'h03);
    rd(MODE_SELECT_OFFSET, MODE_SELECT_RESET);
    foreach (rows[i]) begin
      wr(MODE_SELECT_OFFSET, rows[i][11:4]);
      send = rows[i][3];
      slot = rows[i][2];
      #1 chk({6'h00, line_drv_en, line_rcv_en}, {6'h00, rows[i][1:0]});
      rd(MODE_SELECT_OFFSET, rows[i][11:4]);
    end
    // unmapped offset leaves auto mode in place and reads zero
    wr(3'h3, 8'h00);
    chk({6'h00, line_drv_en, line_rcv_en}, 8'h01);
    rd(3'h3, 8'h00);
    rd(MODE_SELECT_OFFSET, 8'h03);
    // write and read in one cycle: the read returns the byte held before
    @(negedge mclk);
    reg_addr = MODE_SELECT_OFFSET;
    reg_wdata = 8'h01;
    reg_wr = 1;
    reg_rd = 1;
    @(negedge mclk);
    reg_wr = 0;
    reg_rd = 0;
    send = 0;
    chk(reg_rdata, 8'h03);
    #1 chk({6'h00, line_drv_en, line_rcv_en}, 8'h01);
    @(negedge mclk);
    chk(reg_rdata, RDATA_IDLE);
    wr(MODE_SELECT_OFFSET, 8'h02);
    rst_n = 0;
    @(negedge mclk);
    rst_n = 1;
    chk({6'h00, line_drv_en, line_rcv_en}, 8'h03);
    rd(MODE_SELECT_OFFSET, 8'h00);
    results();
  end
endmodule

// ===== tb/uart_side_model.sv
/* stand-in for the uart core: turns host intent into dtr and transmit-ready.
   assumes the bench drives send and tx_slot at the falling edge. */
`timescale 1ns/1ps
module uart_side_model (
  input  wire logic send,        // host wants the line
  input  wire logic tx_slot,     // a byte is leaving the fifo
  output logic      dtr_n,       // dtr, active low
  output logic      slot_ready_n // transmit-ready, active low
);
  // dtr bit cleared while sending, set again once shifted out
  assign dtr_n = send;
  // fifos taken as enabled, so ready pulses per byte
  assign slot_ready_n = !tx_slot;
endmodule

// ===== verilog/rs485_transceiver_direction_ctrl.sv
/*
  rs-485 driver and receiver enable control beside a uart.
  assumes the uart register bus is synchronous to mclk, and that the dtr and
  transmit-ready inputs come straight from the uart core on the same clock.
*/
`timescale 1ns/1ps

module rs485_transceiver_direction_ctrl
  import xcvr_dir_pkg::*;
(
  input  wire logic       mclk,                 // 20 mhz clock
  input  wire logic       rst_n,                // synchronous reset
  input  wire logic [2:0] reg_addr,             // register offset
  input  wire logic       reg_wr,               // write strobe
  input  wire logic       reg_rd,               // read strobe
  input  wire logic [7:0] reg_wdata,            // write data
  output logic      [7:0] reg_rdata,            // read data
  input  wire logic       uart_dtr_n,           // uart dtr output
  input  wire logic       uart_tx_slot_ready_n, // uart transmit-ready output
  output logic            line_drv_en,          // line driver enable
  output logic            line_rcv_en           // line receiver enable
);

  ////////////////////////////////////////////////////////////////////////////
  // register access

  logic [7:0] transceiver_mode_select;
  logic [7:0] next_rdata;
  wire        sel_mode = (reg_addr == MODE_SELECT_OFFSET);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      transceiver_mode_select <= MODE_SELECT_RESET;
    end else if (reg_wr && sel_mode) begin
      transceiver_mode_select <= reg_wdata;
    end
  end

  assign next_rdata = (reg_rd && sel_mode) ? transceiver_mode_select : RDATA_IDLE;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= RDATA_IDLE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode and gating

  function automatic xcvr_mode_e decode_mode(input logic [7:0] b);
    logic [1:0] c;
    c = b[MODE_LSB +: MODE_WIDTH];
    unique case (c)
      CODE_FOUR_WIRE: decode_mode = MODE_FOUR_WIRE;
      CODE_DTR_ECHO:  decode_mode = MODE_DTR_ECHO;
      CODE_DTR_CTRL:  decode_mode = MODE_DTR_CTRL;
      CODE_TX_AUTO:   decode_mode = MODE_TX_AUTO;
    endcase
  endfunction

  xcvr_mode_e mode;
  line_en_s   next_en;
  wire        dtr_on = !uart_dtr_n;
  wire        txr_on = !uart_tx_slot_ready_n;

  assign mode = decode_mode(transceiver_mode_select);

  always_comb begin
    next_en = '{drv_en: 1'b1, rcv_en: 1'b1};
    unique case (mode)
      MODE_FOUR_WIRE: next_en = '{drv_en: 1'b1, rcv_en: 1'b1};
      MODE_DTR_ECHO:  next_en = '{drv_en: !dtr_on, rcv_en: 1'b1};
      MODE_DTR_CTRL:  next_en = '{drv_en: !dtr_on, rcv_en: dtr_on};
      MODE_TX_AUTO:   next_en = '{drv_en: txr_on, rcv_en: !txr_on};
    endcase
  end

  // gating follows the inputs with no added delay; the uart sets dtr
  assign line_drv_en = next_en.drv_en;
  assign line_rcv_en = next_en.rcv_en;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_mode_write(logic [1:0] c);
    reg_wr && sel_mode && reg_wdata[1:0] == c;
  endsequence

  a_four_wire_on: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == MODE_FOUR_WIRE |-> line_drv_en && line_rcv_en)
    else $error("four-wire mode not fully enabled");

  a_echo_gating: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == MODE_DTR_ECHO |-> line_rcv_en && (line_drv_en == uart_dtr_n))
    else $error("echo mode gating wrong");

  a_dtr_gating: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == MODE_DTR_CTRL |-> (line_drv_en == uart_dtr_n) && (line_rcv_en != line_drv_en))
    else $error("dtr mode gating wrong");

  a_auto_gating: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == MODE_TX_AUTO |-> (line_drv_en == !uart_tx_slot_ready_n)
      && (line_rcv_en == uart_tx_slot_ready_n))
    else $error("auto mode gating wrong");

  a_reset_default: assert property (@(posedge mclk)
    !rst_n |=> mode == MODE_FOUR_WIRE)
    else $error("reset did not select four-wire");

  a_write_applies: assert property (@(posedge mclk) disable iff (!rst_n)
    s_mode_write(CODE_DTR_CTRL) |=> mode == MODE_DTR_CTRL)
    else $error("mode write not applied next cycle");

  a_code_auto: assert property (@(posedge mclk) disable iff (!rst_n)
    s_mode_write(CODE_TX_AUTO) |=> mode == MODE_TX_AUTO)
    else $error("code 3 not decoded as auto");

  a_upper_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && sel_mode |=> transceiver_mode_select == $past(reg_wdata)
      && mode == xcvr_mode_e'($past(reg_wdata[1:0])))
    else $error("mode byte stored or decoded wrong");

  a_readback: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && sel_mode && !reg_wr |=> reg_rdata == $past(transceiver_mode_select))
    else $error("scratch readback wrong");

  a_dtr_polarity: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == MODE_DTR_ECHO) && !uart_dtr_n |-> !line_drv_en)
    else $error("asserted dtr left driver on");

  a_echo_follows: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == MODE_DTR_ECHO) && uart_dtr_n |-> line_drv_en)
    else $error("released dtr left echo driver off");

  a_ctrl_polarity: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == MODE_DTR_CTRL) && !uart_dtr_n |-> !line_drv_en && line_rcv_en)
    else $error("asserted dtr did not turn the line around");

  a_auto_polarity: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == MODE_TX_AUTO) && !uart_tx_slot_ready_n |-> line_drv_en && !line_rcv_en)
    else $error("asserted transmit-ready did not enable driver");

  a_auto_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == MODE_TX_AUTO) && uart_tx_slot_ready_n |-> !line_drv_en && line_rcv_en)
    else $error("idle transmit-ready left driver on");

  a_half_duplex: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == MODE_DTR_CTRL || mode == MODE_TX_AUTO) |-> !(line_drv_en && line_rcv_en))
    else $error("driver and receiver both on in two-wire mode");

  a_four_ignores: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == MODE_FOUR_WIRE) && (!uart_dtr_n || !uart_tx_slot_ready_n)
      |-> line_drv_en && line_rcv_en)
    else $error("four-wire mode followed a control line");

  a_code_four: assert property (@(posedge mclk) disable iff (!rst_n)
    s_mode_write(CODE_FOUR_WIRE) |=> mode == MODE_FOUR_WIRE)
    else $error("code 0 not decoded as four-wire");

  a_code_echo: assert property (@(posedge mclk) disable iff (!rst_n)
    s_mode_write(CODE_DTR_ECHO) |=> mode == MODE_DTR_ECHO)
    else $error("code 1 not decoded as echo");

  a_apply_at_once: assert property (@(posedge mclk) disable iff (!rst_n)
    s_mode_write(CODE_DTR_CTRL) ##1 uart_dtr_n |-> line_drv_en && !line_rcv_en)
    else $error("new mode did not gate the line at once");

  a_mode_held: assert property (@(posedge mclk) disable iff (!rst_n)
    !(reg_wr && sel_mode) |=> $stable(transceiver_mode_select))
    else $error("mode byte changed without a write");

  a_other_write: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && !sel_mode |=> $stable(transceiver_mode_select))
    else $error("write to another offset changed the mode byte");

  a_reset_enables: assert property (@(posedge mclk)
    !rst_n |=> line_drv_en && line_rcv_en)
    else $error("enables not both on after reset");

  a_reset_rdata: assert property (@(posedge mclk)
    !rst_n |=> reg_rdata == RDATA_IDLE)
    else $error("read data not idle after reset");

  ////////////////////////////////////////////////////////////////////////////
  // read port checks

  sequence s_mode_read;
    reg_rd && sel_mode;
  endsequence

  sequence s_read_then_idle;
    s_mode_read ##1 !reg_rd;
  endsequence

  a_read_old_value: assert property (@(posedge mclk) disable iff (!rst_n)
    s_mode_read ##0 reg_wr |=> reg_rdata == $past(transceiver_mode_select))
    else $error("same-cycle read did not return the old byte");

  a_other_read: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && !sel_mode |=> reg_rdata == RDATA_IDLE)
    else $error("read of another offset not idle");

  a_rdata_returns: assert property (@(posedge mclk) disable iff (!rst_n)
    s_read_then_idle |=> reg_rdata == RDATA_IDLE)
    else $error("read data did not return to idle");

  a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == RDATA_IDLE)
    else $error("read data shown without a read");

endmodule

// ===== verilog/xcvr_dir_pkg.sv
/*
  shared constants and types for the rs-485 transceiver direction control.
  assumes the uart register bus uses 3-bit offsets and 8-bit data.
*/
package xcvr_dir_pkg;

  localparam logic [2:0] MODE_SELECT_OFFSET = 3'h7;
  localparam logic [7:0] MODE_SELECT_RESET  = 8'h00;
  localparam logic [7:0] RDATA_IDLE         = 8'h00;
  localparam int         MODE_LSB           = 0;
  localparam int         MODE_WIDTH         = 2;

  localparam logic [1:0] CODE_FOUR_WIRE     = 2'h0;
  localparam logic [1:0] CODE_DTR_ECHO      = 2'h1;
  localparam logic [1:0] CODE_DTR_CTRL      = 2'h2;
  localparam logic [1:0] CODE_TX_AUTO       = 2'h3;

  typedef enum logic [1:0] {
    MODE_FOUR_WIRE,
    MODE_DTR_ECHO,
    MODE_DTR_CTRL,
    MODE_TX_AUTO
  } xcvr_mode_e;

  typedef struct packed {
    logic drv_en;
    logic rcv_en;
  } line_en_s;

endpackage
